// File: design/smbus_divider_setting_slave.sv
/*
  bus slave port of a step-down converter controller: word write and
  word read on a fixed address, two 5-bit divider registers, the
  converter-off flag and the open-drain shutdown output.
  assumes scl and sda are open-drain bus lines resolved outside, scl is
  a clock from the master, and clk runs at least four times faster.
*/
module smbus_divider_setting_slave
  import smbus_div_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus link, scl is the link clock
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter control pins
  input wire logic regulator_enable_pin,
  input wire logic setting_select,
  output logic converter_shutdown_output,
  output logic converter_shutdown_oe,
  // divider setting and status
  output logic [4:0] divider_code,
  output logic converter_off_flag
);

  // reset values of both domains
  localparam link_s LINK_RST = '{st: ST_IDLE, cmd: CMD_RDBK, default: '0};
  localparam ctl_s CTL_RST = '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
    sda_s2: 1'b1, sda_d: 1'b1, pcmd: CMD_RDBK, last_cmd: CMD_RDBK,
    flag: 1'b1, sd_oe: 1'b1, default: '0};

  link_s link_r; // scl domain state
  link_s link_nxt; // its next value
  ctl_s ctl_r; // clk domain state
  ctl_s ctl_nxt; // its next value
  logic samp_r; // bit caught on the rising scl edge
  logic start_new; // start seen, not yet taken by the link
  logic [7:0] rx_full; // byte completed by the current bit
  addr_byte_s rx_addr; // same byte read as an address
  cmd_byte_s rx_cmd; // same byte read as a command
  data_byte_s rx_data; // same byte read as data
  rb_byte_s tx_a; // read-back byte for register 0
  rb_byte_s tx_b; // read-back byte for register 1
  logic bus_start; // start condition in clk domain
  logic bus_stop; // stop condition in clk domain
  logic tgl_event; // posted command arrived from link
  logic pend_now; // a write waits for its stop
  cmd_t cmd_now; // the write that waits

  // byte views of the shift register plus the new bit
  assign rx_full = {link_r.sh[BYTE_MSB-1:0], samp_r};
  assign rx_addr = addr_byte_s'(rx_full);
  assign rx_cmd = cmd_byte_s'(rx_full);
  assign rx_data = data_byte_s'(rx_full);
  assign tx_a = '{code: link_r.code_a, off: link_r.flag_s2, zero: PAD_ZERO};
  assign tx_b = '{code: link_r.code_b, off: link_r.flag_s2, zero: PAD_ZERO};

  // the start toggle changes while scl is high and settles well before
  // the falling edge that reads it, so it is read directly with no sync stage here
  assign start_new = (ctl_r.start_tgl != link_r.start_seen);

  // input sampling on the rising scl edge
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      samp_r <= 1'b1;
    end else begin
      samp_r <= sda_in;
    end
  end

  // link state: consumes the caught bit and drives sda on falling scl,
  // so sda only changes while scl is low
  always_comb begin
    link_nxt = link_r;
    // converter-off flag brought over through two stages
    link_nxt.flag_s1 = ctl_r.flag;
    link_nxt.flag_s2 = link_r.flag_s1;
    if (start_new) begin
      // start or repeated start restarts the address byte
      link_nxt.start_seen = ctl_r.start_tgl;
      link_nxt.st = ST_ADDR;
      link_nxt.cnt = '0;
      link_nxt.sda_oe = 1'b0;
    end else begin
      case (link_r.st)
        ST_ADDR: begin
          link_nxt.sh = rx_full;
          link_nxt.cnt = 3'(link_r.cnt + 3'h1);
          if (link_r.cnt == LAST_BIT) begin
            if (rx_addr.addr == DEV_ADDR) begin
              // pull sda low through the ack clock
              link_nxt.st = ST_ADDR_ACK;
              link_nxt.sda_oe = 1'b1;
              link_nxt.rw = rx_addr.rw;
            end else begin
              // not us: stay off the bus until a start
              link_nxt.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          link_nxt.cnt = '0;
          link_nxt.idx = 1'b0;
          if (link_r.rw) begin
            // read: put out the first bit of register 0
            link_nxt.st = ST_RDATA;
            link_nxt.sh = tx_a;
            link_nxt.sda_oe = ~tx_a.code[$high(tx_a.code)];
          end else begin
            link_nxt.st = ST_CMD;
            link_nxt.sda_oe = 1'b0;
          end
        end
        ST_CMD: begin
          link_nxt.sh = rx_full;
          link_nxt.cnt = 3'(link_r.cnt + 3'h1);
          if (link_r.cnt == LAST_BIT) begin
            // only the top three bits are kept
            link_nxt.cmd = rx_cmd.cmd;
            link_nxt.st = ST_CMD_ACK;
            link_nxt.sda_oe = 1'b1;
          end
        end
        ST_CMD_ACK: begin
          // a read now expects a repeated start from the master
          link_nxt.st = ST_WDATA;
          link_nxt.cnt = '0;
          link_nxt.idx = 1'b0;
          link_nxt.sda_oe = 1'b0;
        end
        ST_WDATA: begin
          link_nxt.sh = rx_full;
          link_nxt.cnt = 3'(link_r.cnt + 3'h1);
          if (link_r.cnt == LAST_BIT) begin
            link_nxt.st = ST_WDATA_ACK;
            link_nxt.sda_oe = 1'b1;
            // stored codes only move on setup
            if (link_r.cmd == CMD_SETUP) begin
              if (link_r.idx) begin
                link_nxt.code_b = rx_data.code;
              end else begin
                link_nxt.code_a = rx_data.code;
              end
            end
          end
        end
        ST_WDATA_ACK: begin
          link_nxt.sda_oe = 1'b0;
          link_nxt.cnt = '0;
          if (!link_r.idx) begin
            link_nxt.idx = 1'b1;
            link_nxt.st = ST_WDATA;
          end else begin
            link_nxt.st = ST_IDLE;
            // post the write to the clk domain; cmd stays put meanwhile
            if (link_r.cmd == CMD_ON || link_r.cmd == CMD_OFF
                || link_r.cmd == CMD_SETUP) begin
              link_nxt.cmd_tgl = ~link_r.cmd_tgl;
            end
          end
        end
        ST_RDATA: begin
          link_nxt.sh = link_r.sh << 1;
          link_nxt.cnt = 3'(link_r.cnt + 3'h1);
          if (link_r.cnt == LAST_BIT) begin
            // free sda for the master's ack bit
            link_nxt.st = ST_RDATA_ACK;
            link_nxt.sda_oe = 1'b0;
          end else begin
            link_nxt.sda_oe = ~link_r.sh[BYTE_MSB-1];
          end
        end
        ST_RDATA_ACK: begin
          link_nxt.cnt = '0;
          if (!link_r.idx && !samp_r) begin
            // acked register 0: send register 1
            link_nxt.idx = 1'b1;
            link_nxt.sh = tx_b;
            link_nxt.st = ST_RDATA;
            link_nxt.sda_oe = ~tx_b.code[$high(tx_b.code)];
          end else begin
            // last byte left unacked, or master gave up
            link_nxt.st = ST_IDLE;
            link_nxt.sda_oe = 1'b0;
          end
        end
        default: begin
          link_nxt.st = ST_IDLE;
          link_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // link state register on the falling scl edge
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      link_r <= LINK_RST;
    end else begin
      link_r <= link_nxt;
    end
  end

  // bus conditions seen through the clk synchronisers
  assign bus_start = ctl_r.scl_s2 && ctl_r.sda_d && !ctl_r.sda_s2;
  assign bus_stop = ctl_r.scl_s2 && !ctl_r.sda_d && ctl_r.sda_s2;
  assign tgl_event = (ctl_r.tgl_s2 != ctl_r.tgl_seen);
  // a command arriving with the stop is not lost
  assign pend_now = ctl_r.pending || tgl_event;
  assign cmd_now = tgl_event ? link_r.cmd : ctl_r.pcmd;

  // converter control: a posted write acts at the stop that frames it
  always_comb begin
    ctl_nxt = ctl_r;
    // pins and the link toggle pass two stages first
    ctl_nxt.scl_s1 = scl;
    ctl_nxt.scl_s2 = ctl_r.scl_s1;
    ctl_nxt.sda_s1 = sda_in;
    ctl_nxt.sda_s2 = ctl_r.sda_s1;
    ctl_nxt.sda_d = ctl_r.sda_s2;
    ctl_nxt.en_s1 = regulator_enable_pin;
    ctl_nxt.en_s2 = ctl_r.en_s1;
    ctl_nxt.sel_s1 = setting_select;
    ctl_nxt.sel_s2 = ctl_r.sel_s1;
    ctl_nxt.tgl_s1 = link_r.cmd_tgl;
    ctl_nxt.tgl_s2 = ctl_r.tgl_s1;
    ctl_nxt.tgl_seen = ctl_r.tgl_s2;
    ctl_nxt.pending = pend_now;
    ctl_nxt.pcmd = cmd_now;
    if (bus_start) begin
      // a write cut short by a repeated start is dropped
      ctl_nxt.start_tgl = ~ctl_r.start_tgl;
      ctl_nxt.pending = tgl_event;
    end else if (bus_stop && pend_now) begin
      // word write closed by its stop
      ctl_nxt.pending = 1'b0;
      ctl_nxt.last_cmd = cmd_now;
      case (cmd_now)
        CMD_ON: begin
          if (ctl_r.last_cmd == CMD_ON) begin
            ctl_nxt.flag = 1'b0;
          end
        end
        CMD_OFF: begin
          if (ctl_r.last_cmd == CMD_OFF) begin
            ctl_nxt.flag = 1'b1;
          end
        end
        CMD_SETUP: begin
          // link copies are still since scl has stopped
          ctl_nxt.div_a = link_r.code_a;
          ctl_nxt.div_b = link_r.code_b;
        end
        default: begin
          ctl_nxt.flag = ctl_r.flag;
        end
      endcase
    end
    // setting select drives the divider code
    ctl_nxt.div_out = ctl_r.sel_s2 ? ctl_r.div_b : ctl_r.div_a;
    // shutdown released only with enable high and flag clear
    ctl_nxt.sd_oe = !(ctl_r.en_s2 && !ctl_r.flag);
  end

  // clk domain state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= CTL_RST;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // outputs: open-drain lines only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = link_r.sda_oe;
  assign converter_shutdown_output = 1'b0;
  assign converter_shutdown_oe = ctl_r.sd_oe;
  assign divider_code = ctl_r.div_out;
  assign converter_off_flag = ctl_r.flag;

  // foreign address leaves the bus alone
  addr_miss_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_ADDR && link_r.cnt == LAST_BIT && !start_new
     && rx_addr.addr != DEV_ADDR) |=> (link_r.st == ST_IDLE && !sda_oe)[*2])
    else $error("foreign address was answered");
  // own address acknowledged, then released after one clock on a write
  addr_ack_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_ADDR && link_r.cnt == LAST_BIT && !start_new
     && rx_addr.addr == DEV_ADDR) |=> sda_oe ##1 (link_r.rw || !sda_oe))
    else $error("address ack wrong");
  // command byte acknowledged
  cmd_ack_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_CMD && link_r.cnt == LAST_BIT && !start_new)
    |=> sda_oe && link_r.st == ST_CMD_ACK)
    else $error("command byte not acked");
  // only setup moves stored codes
  code_hold_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_WDATA && link_r.cmd != CMD_SETUP)
    |=> $stable(link_r.code_a) && $stable(link_r.code_b))
    else $error("stored code changed outside setup");
  // second write ack returns to idle
  write_end_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_WDATA_ACK && link_r.idx && !start_new)
    |=> link_r.st == ST_IDLE && !sda_oe)
    else $error("no idle after write");
  // read-back byte layout
  read_byte_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_ADDR_ACK && link_r.rw && !start_new)
    |=> link_r.sh[1:0] == PAD_ZERO && link_r.sh[BYTE_MSB -: 5] == $past(link_r.code_a))
    else $error("read byte layout wrong");
  // second read byte ends the transfer
  read_end_a: assert property (@(negedge scl) disable iff (!rst_n)
    (link_r.st == ST_RDATA_ACK && link_r.idx && !start_new)
    |=> link_r.st == ST_IDLE && !sda_oe)
    else $error("no idle after read");
  // two ons in a row clear the flag
  double_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!bus_start && bus_stop && pend_now && cmd_now == CMD_ON
     && ctl_r.last_cmd == CMD_ON) |=> !converter_off_flag)
    else $error("double on did not clear flag");
  // two offs in a row set the flag
  double_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!bus_start && bus_stop && pend_now && cmd_now == CMD_OFF
     && ctl_r.last_cmd == CMD_OFF) |=> converter_off_flag)
    else $error("double off did not set flag");

  // shutdown released one clock after enable high with flag clear
  shutdown_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctl_r.en_s2 && !ctl_r.flag) |=> !converter_shutdown_oe)
    else $error("shutdown not released");
  // enable low forces shutdown whatever the flag holds
  enable_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl_r.en_s2 |=> converter_shutdown_oe)
    else $error("enable low did not shut down");

endmodule

// File: pkg/smbus_div_pkg.sv
/*
  package for the bus-programmed divider setting port: bus address,
  command codes, byte layouts, link states and the state records of
  both clock domains.
  assumes nothing beyond a SystemVerilog-2012 tool.
*/
package smbus_div_pkg;

  // fixed 7-bit bus address of the port
  localparam logic [6:0] DEV_ADDR = 7'h71;
  // bit index of the last bit in a byte, and the byte msb
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int BYTE_MSB = 7;
  // two unused low bits of a read-back byte
  localparam logic [1:0] PAD_ZERO = 2'h0;

  // command code held in the top three bits of the command byte
  typedef logic [2:0] cmd_t;
  localparam cmd_t CMD_ON = 3'h0;
  localparam cmd_t CMD_SETUP = 3'h1;
  localparam cmd_t CMD_RDBK = 3'h2;
  localparam cmd_t CMD_OFF = 3'h3;

  // byte layouts on the wire, msb first
  typedef struct packed {
    logic [6:0] addr;
    logic rw;
  } addr_byte_s;
  typedef struct packed {
    cmd_t cmd;
    logic [4:0] rest;
  } cmd_byte_s;
  typedef struct packed {
    logic [4:0] code;
    logic [2:0] rest;
  } data_byte_s;
  typedef struct packed {
    logic [4:0] code;
    logic off;
    logic [1:0] zero;
  } rb_byte_s;

  // link side states, advanced on the falling scl edge
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } link_st_e;

  // all falling-edge state of the scl domain
  typedef struct packed {
    link_st_e st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic idx;
    logic rw;
    cmd_t cmd;
    logic [4:0] code_a;
    logic [4:0] code_b;
    logic cmd_tgl;
    logic start_seen;
    logic flag_s1;
    logic flag_s2;
    logic sda_oe;
  } link_s;

  // all state of the system clock domain
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic en_s1;
    logic en_s2;
    logic sel_s1;
    logic sel_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_seen;
    logic start_tgl;
    logic pending;
    cmd_t pcmd;
    cmd_t last_cmd;
    logic flag;
    logic [4:0] div_a;
    logic [4:0] div_b;
    logic [4:0] div_out;
    logic sd_oe;
  } ctl_s;

endpackage

// File: sim/smbus_divider_setting_slave_test.sv
/*
  self-checking bench for the divider setting port: writes, reads,
  command pairs and enable pin through the bus master model.
  assumes the master model above and the design's stop-time effects.
*/
module smbus_divider_setting_slave_test;
  timeunit 1ns;
  timeprecision 100ps;

  // design pins
  logic clk = 1'b0;
  logic rst_n;
  logic en;
  logic sel;
  wire scl;
  wire m_low;
  logic sda_out;
  logic sda_oe;
  logic shd_out;
  logic shd_oe;
  logic [4:0] code;
  logic off_flag;
  // pulled-up open-drain sda, either party may pull it low
  wire sda_line = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  // bench bookkeeping
  int fail_count;
  int checks;
  int cycles;
  logic [3:0] wa;
  logic [2:0] ra;
  logic [7:0] b0;
  logic [7:0] b1;

  smbus_divider_setting_slave i_smbus_divider_setting_slave (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .regulator_enable_pin(en), .setting_select(sel), .converter_shutdown_output(shd_out),
    .converter_shutdown_oe(shd_oe), .divider_code(code), .converter_off_flag(off_flag)
  );

  smbus_host_model i_smbus_host_model (.scl(scl), .sda_low(m_low), .sda(sda_line));

  // 250 MHz system clock
  always #2 clk = ~clk;

  // hang guard, the full run needs about 8300 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  // single compare for bytes, codes and flags, zero extended
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // stop effects land a few clk later, give them room
  task automatic settle();
    repeat (20) @(posedge clk);
    #1;
  endtask

  // pin changes just after a clock edge
  task automatic pins(input logic e, input logic s);
    @(posedge clk);
    #1 en = e;
    sel = s;
    settle();
  endtask

  // fixed address write, acknowledge pattern checked each time
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
    i_smbus_host_model.write_word(7'h71, cmd, d0, d1, wa);
    check_val({4'h0, wa}, 8'h0F);
    settle();
  endtask

  // read back and compare both bytes
  task automatic rd(input logic [7:0] e0, input logic [7:0] e1);
    i_smbus_host_model.read_word(7'h71, 8'h40, b0, b1, ra);
    check_val({5'h00, ra}, 8'h07);
    check_val(b0, e0);
    check_val(b1, e1);
    settle();
  endtask

  initial begin
    rst_n = 1'b0;
    en = 1'b0;
    sel = 1'b0;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    // reset state: converter held off, bus released
    check_val({7'h00, off_flag}, 8'h01);
    check_val({7'h00, shd_oe}, 8'h01);
    check_val({7'h00, shd_out}, 8'h00);
    check_val({7'h00, sda_oe}, 8'h00);
    check_val({3'h0, code}, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    // setup with junk in low command and data bits
    wr(8'h3F, {5'h15, 3'h7}, {5'h0A, 3'h0});
    check_val({3'h0, code}, 8'h15);
    pins(1'b0, 1'b1);
    check_val({3'h0, code}, 8'h0A);
    rd(8'hAC, 8'h54);
    // foreign address: no acknowledge at all, nothing stored
    i_smbus_host_model.write_word(7'h70, 8'h20, 8'hFF, 8'hFF, wa);
    check_val({4'h0, wa}, 8'h00);
    settle();
    // undefined command is acknowledged but changes nothing
    wr(8'hE0, 8'hFF, 8'hFF);
    // single on must not clear the flag, data not stored
    wr(8'h00, 8'hFF, 8'hFF);
    check_val({7'h00, off_flag}, 8'h01);
    check_val({3'h0, code}, 8'h0A);
    wr(8'h1F, 8'h00, 8'h00);
    check_val({7'h00, off_flag}, 8'h00);
    check_val({7'h00, shd_oe}, 8'h01);
    pins(1'b1, 1'b0);
    check_val({7'h00, shd_oe}, 8'h00);
    check_val({3'h0, code}, 8'h15);
    rd(8'hA8, 8'h50);
    // read between offs does not break the pair
    wr(8'h60, 8'h00, 8'h00);
    check_val({7'h00, off_flag}, 8'h00);
    rd(8'hA8, 8'h50);
    wr(8'h7F, 8'h00, 8'h00);
    check_val({7'h00, off_flag}, 8'h01);
    check_val({7'h00, shd_oe}, 8'h01);
    // turn on again, then pull enable low for immediate shutdown
    wr(8'h00, 8'h00, 8'h00);
    wr(8'h00, 8'h00, 8'h00);
    check_val({7'h00, shd_oe}, 8'h00);
    pins(1'b0, 1'b0);
    check_val({7'h00, shd_oe}, 8'h01);
    check_val({7'h00, off_flag}, 8'h00);
    report_and_stop();
  end
endmodule

// File: sim/smbus_host_model.sv
/*
  behavioural bus master for the divider setting port: start, repeated
  start, stop, byte send and receive, word write and word read.
  assumes sda is a pulled-up open-drain line resolved by the bench and
  that scl is driven only by this model, 64 ns per bit.
*/
module smbus_host_model (
  // link pins
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: both lines released high, clock stands still
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data changes mid low phase, well clear of the rising sample edge
  task automatic bit_out(input logic b);
    #16 sda_low = !b;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
  endtask

  // release sda and sample after the rise, device drives on the fall
  task automatic bit_in(output logic b);
    #16 sda_low = 1'b0;
    #16 scl = 1'b1;
    #8 b = sda;
    #24 scl = 1'b0;
  endtask

  // falling sda while scl high; scl held high 32 ns for the synchronisers
  task automatic start_bit();
    #16 sda_low = 1'b1;
    #32 scl = 1'b0;
  endtask

  // repeated start from scl low, no stop in between
  task automatic rep_start();
    #16 sda_low = 1'b0;
    #16 scl = 1'b1;
    #32 sda_low = 1'b1;
    #32 scl = 1'b0;
  endtask

  // rising sda while scl high, then bus stays idle a while
  task automatic stop_bit();
    #16 sda_low = 1'b1;
    #16 scl = 1'b1;
    #32 sda_low = 1'b0;
    #64;
  endtask

  // msb first, returns the acknowledge seen from the device
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(a);
    ack = !a;
  endtask

  // receive one byte, then acknowledge it or not
  task automatic get_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(!ack);
  endtask

  // four bytes between start and stop, data sent even when refused
  task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] d0,
                            input logic [7:0] d1, output logic [3:0] acks);
    start_bit();
    send_byte({adr, 1'b0}, acks[3]);
    send_byte(cmd, acks[2]);
    send_byte(d0, acks[1]);
    send_byte(d1, acks[0]);
    stop_bit();
  endtask

  // command, repeated start, address with read bit, two bytes
  task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd, output logic [7:0] b0,
                           output logic [7:0] b1, output logic [2:0] acks);
    start_bit();
    send_byte({adr, 1'b0}, acks[2]);
    send_byte(cmd, acks[1]);
    rep_start();
    send_byte({adr, 1'b1}, acks[0]);
    get_byte(1'b1, b0);
    get_byte(1'b0, b1);
    stop_bit();
  endtask
endmodule
